// ===== core/tpl_cfg.svh
/*
 * touch probe capture: register indexes, field positions, reset values.
 * assumes inclusion by bare name from the core/ include path.
 */
`ifndef TPL_CFG_SVH
`define TPL_CFG_SVH

// word indexes, byte address is four times the index
`define TPL_IDX_CONTROL     16'h60B8
`define TPL_IDX_STATUS      16'h60B9
`define TPL_IDX_P1_RISE     16'h60BA
`define TPL_IDX_P1_FALL     16'h60BB
`define TPL_IDX_P2_RISE     16'h60BC
`define TPL_IDX_P2_FALL     16'h60BD
`define TPL_IDX_IRQ_STATUS  16'h60BE
`define TPL_IDX_IRQ_MASK    16'h60BF
`define TPL_IDX_P1_RISE_CNT 16'h60D5
`define TPL_IDX_P1_FALL_CNT 16'h60D6
`define TPL_IDX_P2_RISE_CNT 16'h60D7
`define TPL_IDX_P2_FALL_CNT 16'h60D8

// lsb of each probe's byte in control and status words
`define TPL_P1_LSB 0
`define TPL_P2_LSB 8

// control fields within a probe byte
`define TPL_CTL_EN   0
`define TPL_CTL_MODE 1
`define TPL_CTL_SRC  2
`define TPL_CTL_RISE 4
`define TPL_CTL_FALL 5

// status fields within a probe byte
`define TPL_ST_EN    0
`define TPL_ST_RDONE 1
`define TPL_ST_FDONE 2

// interrupt event bits
`define TPL_EV_P1_RISE 0
`define TPL_EV_P1_FALL 1
`define TPL_EV_P2_RISE 2
`define TPL_EV_P2_FALL 3

// reset values
`define TPL_CTRL_RST 16'h0000
`define TPL_IRQ_RST  4'h0
`define TPL_MASK_RST 4'h0
`define TPL_RD_RST   32'h00000000

`endif

// ===== core/tpl_pkg.sv
/*
 * touch probe capture: shared types.
 * assumes nothing of its surroundings.
 */
package tpl_pkg;
	typedef logic [31:0] tpl_word_t;
	typedef logic [15:0] tpl_index_t;
	typedef logic [7:0]  tpl_probe_ctl_t;
	typedef logic [3:0]  tpl_events_t;
	// codes follow declaration order, matching ahb htrans
	typedef enum logic [1:0] {tpl_tr_idle, tpl_tr_busy, tpl_tr_nonseq, tpl_tr_seq} tpl_htrans_t;
	localparam logic [2:0] TPL_HSIZE_WORD = 3'h2;
endpackage

// ===== core/tpl_probe.sv
/*
 * one touch probe channel: source select, edge detect, position latch,
 * executed flags and edge counters.
 * assumes ext_level and index_level already synchronised to core_clk.
 */
`timescale 1ns/1ps
`include "tpl_cfg.svh"

module tpl_probe #(
	parameter int POS_W = 32,
	parameter int CNT_W = 32
) (
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire tpl_pkg::tpl_probe_ctl_t ctrl,
	input  wire logic                 ctrl_changed,
	input  wire logic                 ext_level,
	input  wire logic                 index_level,
	input  wire logic [POS_W-1:0]     position,
	output logic      [POS_W-1:0]     rise_pos,
	output logic      [POS_W-1:0]     fall_pos,
	output logic      [CNT_W-1:0]     rise_cnt,
	output logic      [CNT_W-1:0]     fall_cnt,
	output logic                      rise_done,
	output logic                      fall_done,
	output logic                      rise_fire,
	output logic                      fall_fire
);
	logic trig;
	logic trig_prev;
	logic enabled;
	logic armed;

	assign trig    = ctrl[`TPL_CTL_SRC] ? index_level : ext_level;
	assign enabled = ctrl[`TPL_CTL_EN];
	// single mode stops after the first capture until re-armed
	assign armed   = ctrl[`TPL_CTL_MODE] | ~(rise_done | fall_done);
	assign rise_fire = enabled & ctrl[`TPL_CTL_RISE] & trig & ~trig_prev & armed;
	// single mode with both edges keeps only the rising one
	assign fall_fire = enabled & ctrl[`TPL_CTL_FALL] & ~trig & trig_prev & armed
		& (ctrl[`TPL_CTL_MODE] | ~ctrl[`TPL_CTL_RISE]);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trig;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_pos <= '0;
			fall_pos <= '0;
		end else begin
			if (rise_fire) begin
				rise_pos <= position;
			end
			if (fall_fire) begin
				fall_pos <= position;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_done <= 1'b0;
			fall_done <= 1'b0;
		end else if (!enabled) begin
			rise_done <= 1'b0;
			fall_done <= 1'b0;
		end else begin
			rise_done <= rise_done | rise_fire;
			fall_done <= fall_done | fall_fire;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_cnt <= '0;
			fall_cnt <= '0;
		end else if (ctrl_changed) begin
			rise_cnt <= CNT_W'(rise_fire);
			fall_cnt <= CNT_W'(fall_fire);
		end else begin
			rise_cnt <= rise_cnt + CNT_W'(rise_fire);
			fall_cnt <= fall_cnt + CNT_W'(fall_fire);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_rise_latch: assert property (rise_fire |=> rise_pos == $past(position) && rise_done)
		else $error("rising capture not latched");
	chk_fall_latch: assert property (fall_fire |=> fall_pos == $past(position) && fall_done)
		else $error("falling capture not latched");
	chk_single_once: assert property (!ctrl[`TPL_CTL_MODE] && (rise_done || fall_done)
		|-> !rise_fire && !fall_fire)
		else $error("single mode captured twice");
	chk_single_rise_only: assert property (!ctrl[`TPL_CTL_MODE] && ctrl[`TPL_CTL_RISE]
		|-> !fall_fire)
		else $error("single mode took a falling edge");
	chk_disable_clear: assert property (!enabled |=> !rise_done && !fall_done)
		else $error("executed flag survived disable");
	chk_cnt_restart: assert property (ctrl_changed |=> rise_cnt == CNT_W'($past(rise_fire))
		&& fall_cnt == CNT_W'($past(fall_fire)))
		else $error("edge counters not restarted");
	chk_rise_gate: assert property (rise_fire |-> enabled && ctrl[`TPL_CTL_RISE]
		&& $past(trig) == 1'b0)
		else $error("rising capture without enable");
endmodule

// ===== core/tpl_top.sv
/*
 * touch probe capture top: ahb-lite register slave, pin synchronisers,
 * two capture channels, sticky interrupt status with mask.
 * assumes one ahb-lite master doing single word transfers, probe pins
 * and index pulse asynchronous to core_clk, actual_position on core_clk.
 */
// Notes on behaviour
// - control bit 0 enables probe one
// - separate enable bit for probe two
// - mode bit: single first trigger, else continuous
// - probe one source: input one or index
// - probe two source: input two or index
// - probe one rising capture needs its enable
// - probe one falling capture needs its enable
// - probe two has own edge enables
// - status bits 0-2 report probe one
// - status bits 8-10 report probe two
// - probe one stores per edge register
// - probe two stores per edge register
// - capture latches actual position at edge
// - single mode both edges: rising only
// - changed control word restarts edge counters
`timescale 1ns/1ps
`include "tpl_cfg.svh"

module tpl_top (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        probe_input_one,
	input  wire logic        probe_input_two,
	input  wire logic        encoder_index_pulse,
	input  wire logic [31:0] actual_position,
	output logic             irq
);
	// three pins: probe one, probe two, index
	logic [2:0]            sync_a;
	logic [2:0]            sync_b;
	logic                  bus_take;
	logic                  bus_read;
	logic                  wr_pend;
	logic [31:0]           wr_addr;
	logic                  ctrl_wr;
	logic                  mask_wr;
	logic                  ctrl_changed;
	logic                  irq_rd_clr;
	logic [15:0]           ctrl;
	logic [15:0]           next_ctrl;
	logic [15:0]           status_word;
	tpl_pkg::tpl_events_t  events;
	tpl_pkg::tpl_events_t  irq_status;
	tpl_pkg::tpl_events_t  next_irq_status;
	tpl_pkg::tpl_events_t  irq_mask;
	tpl_pkg::tpl_word_t    rd_value;
	logic [31:0]           p1_rise_pos;
	logic [31:0]           p1_fall_pos;
	logic [31:0]           p2_rise_pos;
	logic [31:0]           p2_fall_pos;
	logic [31:0]           p1_rise_cnt;
	logic [31:0]           p1_fall_cnt;
	logic [31:0]           p2_rise_cnt;
	logic [31:0]           p2_fall_cnt;
	logic                  p1_rise_done;
	logic                  p1_fall_done;
	logic                  p2_rise_done;
	logic                  p2_fall_done;
	logic                  p1_rise_fire;
	logic                  p1_fall_fire;
	logic                  p2_rise_fire;
	logic                  p2_fall_fire;

	function automatic logic tpl_hit(input logic [31:0] addr, input tpl_pkg::tpl_index_t idx);
		tpl_hit = (addr == {14'h0000, idx, 2'h0});
	endfunction

	// pin synchronisers, first stage feeds only the second
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {encoder_index_pulse, probe_input_two, probe_input_one};
			sync_b <= sync_a;
		end
	end

	// bus address phase qualification
	assign bus_take = hsel & hready & htrans[1] & (hsize == tpl_pkg::TPL_HSIZE_WORD);
	assign bus_read = bus_take & ~hwrite;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h00000000;
		end else if (hready) begin
			wr_pend <= bus_take & hwrite;
			wr_addr <= haddr;
		end
	end

	// zero wait state, always okay
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// data phase writes
	assign ctrl_wr      = wr_pend & tpl_hit(wr_addr, `TPL_IDX_CONTROL);
	assign mask_wr      = wr_pend & tpl_hit(wr_addr, `TPL_IDX_IRQ_MASK);
	assign next_ctrl    = ctrl_wr ? hwdata[15:0] : ctrl;
	assign ctrl_changed = ctrl_wr & (hwdata[15:0] != ctrl);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= `TPL_CTRL_RST;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask <= `TPL_MASK_RST;
		end else if (mask_wr) begin
			irq_mask <= hwdata[3:0];
		end
	end

	// capture channels, one byte of control each
	tpl_probe #(
		.POS_W (32),
		.CNT_W (32)
	) u_probe_one (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.ctrl         (ctrl[`TPL_P1_LSB +: 8]),
		.ctrl_changed (ctrl_changed),
		.ext_level    (sync_b[0]),
		.index_level  (sync_b[2]),
		.position     (actual_position),
		.rise_pos     (p1_rise_pos),
		.fall_pos     (p1_fall_pos),
		.rise_cnt     (p1_rise_cnt),
		.fall_cnt     (p1_fall_cnt),
		.rise_done    (p1_rise_done),
		.fall_done    (p1_fall_done),
		.rise_fire    (p1_rise_fire),
		.fall_fire    (p1_fall_fire)
	);

	tpl_probe #(
		.POS_W (32),
		.CNT_W (32)
	) u_probe_two (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.ctrl         (ctrl[`TPL_P2_LSB +: 8]),
		.ctrl_changed (ctrl_changed),
		.ext_level    (sync_b[1]),
		.index_level  (sync_b[2]),
		.position     (actual_position),
		.rise_pos     (p2_rise_pos),
		.fall_pos     (p2_fall_pos),
		.rise_cnt     (p2_rise_cnt),
		.fall_cnt     (p2_fall_cnt),
		.rise_done    (p2_rise_done),
		.fall_done    (p2_fall_done),
		.rise_fire    (p2_rise_fire),
		.fall_fire    (p2_fall_fire)
	);

	// status word, unused bits read zero
	always_comb begin
		status_word = 16'h0000;
		status_word[`TPL_P1_LSB + `TPL_ST_EN]    = ctrl[`TPL_P1_LSB + `TPL_CTL_EN];
		status_word[`TPL_P1_LSB + `TPL_ST_RDONE] = p1_rise_done;
		status_word[`TPL_P1_LSB + `TPL_ST_FDONE] = p1_fall_done;
		status_word[`TPL_P2_LSB + `TPL_ST_EN]    = ctrl[`TPL_P2_LSB + `TPL_CTL_EN];
		status_word[`TPL_P2_LSB + `TPL_ST_RDONE] = p2_rise_done;
		status_word[`TPL_P2_LSB + `TPL_ST_FDONE] = p2_fall_done;
	end

	// interrupt events, set wins over read clear
	always_comb begin
		events = 4'h0;
		events[`TPL_EV_P1_RISE] = p1_rise_fire;
		events[`TPL_EV_P1_FALL] = p1_fall_fire;
		events[`TPL_EV_P2_RISE] = p2_rise_fire;
		events[`TPL_EV_P2_FALL] = p2_fall_fire;
	end

	assign irq_rd_clr      = bus_read & tpl_hit(haddr, `TPL_IDX_IRQ_STATUS);
	assign next_irq_status = (irq_rd_clr ? 4'h0 : irq_status) | events;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= `TPL_IRQ_RST;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// read mux on the address phase, unmapped reads zero
	always_comb begin
		rd_value = 32'h00000000;
		if (tpl_hit(haddr, `TPL_IDX_CONTROL)) begin
			rd_value = {16'h0000, ctrl};
		end else if (tpl_hit(haddr, `TPL_IDX_STATUS)) begin
			rd_value = {16'h0000, status_word};
		end else if (tpl_hit(haddr, `TPL_IDX_P1_RISE)) begin
			rd_value = p1_rise_pos;
		end else if (tpl_hit(haddr, `TPL_IDX_P1_FALL)) begin
			rd_value = p1_fall_pos;
		end else if (tpl_hit(haddr, `TPL_IDX_P2_RISE)) begin
			rd_value = p2_rise_pos;
		end else if (tpl_hit(haddr, `TPL_IDX_P2_FALL)) begin
			rd_value = p2_fall_pos;
		end else if (tpl_hit(haddr, `TPL_IDX_IRQ_STATUS)) begin
			rd_value = {28'h0000000, irq_status};
		end else if (tpl_hit(haddr, `TPL_IDX_IRQ_MASK)) begin
			rd_value = {28'h0000000, irq_mask};
		end else if (tpl_hit(haddr, `TPL_IDX_P1_RISE_CNT)) begin
			rd_value = p1_rise_cnt;
		end else if (tpl_hit(haddr, `TPL_IDX_P1_FALL_CNT)) begin
			rd_value = p1_fall_cnt;
		end else if (tpl_hit(haddr, `TPL_IDX_P2_RISE_CNT)) begin
			rd_value = p2_rise_cnt;
		end else if (tpl_hit(haddr, `TPL_IDX_P2_FALL_CNT)) begin
			rd_value = p2_fall_cnt;
		end
	end

	// sampled at the address phase edge, stands through the data phase
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= `TPL_RD_RST;
		end else if (bus_read) begin
			hrdata <= rd_value;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_ctrl_write: assert property (ctrl_wr |=> ctrl == $past(hwdata[15:0]))
		else $error("control word write lost");
	chk_status_one: assert property (p1_rise_fire |=> status_word[1]
		&& status_word[0] == ctrl[0])
		else $error("probe one status wrong");
	chk_status_two: assert property (p2_fall_fire |=> status_word[10]
		&& status_word[8] == ctrl[8])
		else $error("probe two status wrong");
	chk_src_index: assert property (
		ctrl[2] && ctrl[0] && ctrl[4] && ctrl[1] && $stable(ctrl[7:0])
		&& $rose(sync_b[2]) && !ctrl_wr |-> p1_rise_fire)
		else $error("index source not routed to probe one");
	chk_src_pin_two: assert property (
		!ctrl[10] && ctrl[8] && ctrl[13] && ctrl[9] && $stable(ctrl[15:8])
		&& $fell(sync_b[1]) && !ctrl_wr |-> p2_fall_fire)
		else $error("pin two not routed to probe two");
	chk_irq_raise: assert property (|(irq_status & irq_mask) |=> irq)
		else $error("unmasked event gave no interrupt");
	chk_read_clear: assert property (irq_rd_clr && events == 4'h0 ##1 !wr_pend
		|-> irq_status == 4'h0 ##1 !irq || |(irq_status & irq_mask))
		else $error("status read did not clear");
	chk_hrdata_hold: assert property (bus_read |=> hrdata == $past(rd_value)
		&& hreadyout && !hresp)
		else $error("read data not presented");

	// bus side
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
	chk_wr_capture: assert property (bus_take && hwrite
		|=> wr_pend && wr_addr == $past(haddr))
		else $error("write address phase not held");
	chk_ctrl_hold: assert property (!ctrl_wr |=> ctrl == $past(ctrl))
		else $error("control word changed without write");
	chk_mask_write: assert property (mask_wr |=> irq_mask == $past(hwdata[3:0]))
		else $error("mask write lost");

	// probe routing, storage and status
	chk_pin_one_route: assert property (
		!ctrl[2] && ctrl[0] && ctrl[1] && ctrl[5] && $stable(ctrl[7:0])
		&& $fell(sync_b[0]) |-> p1_fall_fire)
		else $error("pin one not routed to probe one");
	chk_index_two_route: assert property (
		ctrl[10] && ctrl[8] && ctrl[9] && ctrl[12] && $stable(ctrl[15:8])
		&& $rose(sync_b[2]) |-> p2_rise_fire)
		else $error("index source not routed to probe two");
	chk_p1_off_quiet: assert property (!ctrl[0] |-> !p1_rise_fire && !p1_fall_fire)
		else $error("disabled probe one captured");
	chk_p2_off_quiet: assert property (!ctrl[8] |-> !p2_rise_fire && !p2_fall_fire)
		else $error("disabled probe two captured");
	chk_p1_fall_store: assert property (
		p1_fall_fire |=> p1_fall_pos == $past(actual_position))
		else $error("probe one fall position wrong");
	chk_p2_rise_store: assert property (
		p2_rise_fire |=> p2_rise_pos == $past(actual_position))
		else $error("probe two rise position wrong");
	chk_status_enable: assert property (
		status_word[0] == ctrl[0] && status_word[8] == ctrl[8])
		else $error("status enable bits wrong");
	chk_status_spare: assert property ((status_word & 16'hF8F8) == 16'h0000)
		else $error("spare status bits set");
	chk_sync_two: assert property (1'b1 |=> sync_b == $past(sync_a))
		else $error("pin synchroniser skipped a stage");

	// interrupt path
	chk_irq_sticky: assert property (!irq_rd_clr |=>
		(irq_status & $past(irq_status)) == $past(irq_status))
		else $error("status bit lost without read");
	chk_event_wins: assert property (events != 4'h0 |=>
		(irq_status & $past(events)) == $past(events))
		else $error("event did not set status");
	chk_irq_quiet: assert property ((irq_status & irq_mask) == 4'h0 |=> !irq)
		else $error("interrupt without unmasked status");

	cov_p1_single: cover property (!ctrl[1] && p1_rise_fire ##[1:100] !ctrl[0]);
	cov_p1_both: cover property (ctrl[1] && p1_rise_fire ##[1:200] p1_fall_fire);
	cov_p2_fall: cover property (p2_fall_fire ##[1:20] irq);
	cov_restart: cover property (ctrl_changed && p1_rise_cnt != 32'h00000000);
	cov_p2_index: cover property (ctrl[10] && p2_rise_fire);
endmodule

// ===== bench/tpl_pins_model.sv
/*
 * far side of the capture block: a free running encoder position and the
 * two probe pins plus the index pulse, driven from level requests.
 * assumes the bench sets req_lvl by non-blocking assignment at core_clk.
 */
`timescale 1ns/1ps

module tpl_pins_model (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [31:0] pos_base,
	input  wire logic [31:0] pos_step,
	input  wire logic [2:0]  req_lvl,
	output logic      [31:0] actual_position,
	output logic             probe_input_one,
	output logic             probe_input_two,
	output logic             encoder_index_pulse,
	output logic      [31:0] cyc,
	output logic      [31:0] stamp
);
	// position moves every cycle so a late or early latch shows
	assign actual_position = pos_base + pos_step * cyc;

	// stamp holds the cycle number in which the last pin change appeared
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc                 <= 32'h00000000;
			stamp               <= 32'h00000000;
			probe_input_one     <= 1'b0;
			probe_input_two     <= 1'b0;
			encoder_index_pulse <= 1'b0;
		end else begin
			cyc                 <= cyc + 32'h00000001;
			probe_input_one     <= req_lvl[0];
			probe_input_two     <= req_lvl[1];
			encoder_index_pulse <= req_lvl[2];
			if (req_lvl !== {encoder_index_pulse, probe_input_two, probe_input_one}) begin
				stamp <= cyc + 32'h00000001;
			end
		end
	end
endmodule

// ===== bench/touch_probe_position_latch_tb.sv
/*
 * self-checking bench of the touch probe capture top: ahb-lite master
 * tasks, random pulses on the probe pins and index, register checks.
 * assumes zero wait-state slave and three-edge capture of the position.
 */
`timescale 1ns/1ps
`include "tpl_cfg.svh"

module touch_probe_position_latch_tb;
	logic        core_clk;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        pin_one;
	logic        pin_two;
	logic        pin_idx;
	logic [31:0] position;
	logic        irq;
	logic [31:0] pos_base;
	logic [31:0] pos_step;
	logic [2:0]  req_lvl;
	logic [31:0] cyc;
	logic [31:0] stamp;
	logic [31:0] rd;
	logic [31:0] kr;
	logic [31:0] kf;
	logic [31:0] pexp [4];
	integer      seed;
	int          mismatches;
	int          tests_run;

	assign hready = hreadyout;

	tpl_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .probe_input_one(pin_one),
		.probe_input_two(pin_two), .encoder_index_pulse(pin_idx),
		.actual_position(position), .irq(irq));

	tpl_pins_model u_model (.core_clk(core_clk), .arst_n(arst_n), .pos_base(pos_base),
		.pos_step(pos_step), .req_lvl(req_lvl), .actual_position(position),
		.probe_input_one(pin_one), .probe_input_two(pin_two),
		.encoder_index_pulse(pin_idx), .cyc(cyc), .stamp(stamp));

	always #2.5 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one edge, then further edges until hready is seen high
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge core_clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 64) begin
				mismatches++;
				$display("ERROR hready expected 1 seen timeout");
				tally_and_finish;
			end
			@(posedge core_clk);
		end
	endtask

	task automatic bus(input logic wr, input int idx, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= 32'(idx * 4);
		htrans <= tpl_pkg::tpl_tr_nonseq;
		hwrite <= wr;
		hsize  <= tpl_pkg::TPL_HSIZE_WORD;
		wait_ready;
		htrans <= tpl_pkg::tpl_tr_idle;
		hwdata <= wd;
		wait_ready;
		rdv = hrdata;
		check_bit("hresp", 1'b0, hresp);
	endtask

	task automatic wr_reg(input int idx, input logic [31:0] wd);
		logic [31:0] dummy;
		bus(1'b1, idx, wd, dummy);
	endtask

	task automatic rd_reg(input int idx, output logic [31:0] v);
		bus(1'b0, idx, 32'h00000000, v);
	endtask

	// high then low on one pin, stamps of both changes returned
	task automatic pulse(input int pin, output logic [31:0] k_r, output logic [31:0] k_f);
		int w;
		w = 4 + ($unsigned($random(seed)) % 6);
		@(posedge core_clk);
		req_lvl[pin] <= 1'b1;
		@(posedge core_clk);
		#1 k_r = stamp;
		repeat (w) @(posedge core_clk);
		req_lvl[pin] <= 1'b0;
		@(posedge core_clk);
		#1 k_f = stamp;
		repeat (w) @(posedge core_clk);
	endtask

	function automatic logic [31:0] exp_pos(input logic [31:0] k);
		return pos_base + pos_step * (k + 32'h00000002);
	endfunction

	function automatic logic [31:0] ctl(input int p, input logic en, input logic mode,
		input logic src, input logic rise, input logic fall);
		logic [7:0] b;
		b = {2'h0, fall, rise, 1'b0, src, mode, en};
		return (p == 1) ? {16'h0000, b, 8'h00} : {24'h000000, b};
	endfunction

	function automatic logic [15:0] st(input int p, input logic en, input logic rdn,
		input logic fdn);
		logic [7:0] b;
		b = {5'h00, fdn, rdn, en};
		return (p == 1) ? {b, 8'h00} : {8'h00, b};
	endfunction

	task automatic check_probe(input int p, input logic [15:0] st_exp);
		logic [31:0] v;
		rd_reg(`TPL_IDX_P1_RISE + 2 * p, v);
		check_word("rise position", pexp[2 * p], v);
		rd_reg(`TPL_IDX_P1_FALL + 2 * p, v);
		check_word("fall position", pexp[2 * p + 1], v);
		rd_reg(`TPL_IDX_STATUS, v);
		check_word("status word", {16'h0000, st_exp}, v);
	endtask

	initial begin
		seed = 32'h7F78;
		core_clk = 1'b0;
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		req_lvl = 3'h0;
		mismatches = 0;
		tests_run = 0;
		pos_base = $random(seed);
		pos_step = ($random(seed) & 32'h000000FF) | 32'h00000001;
		for (int i = 0; i < 4; i++) pexp[i] = 32'h00000000;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;

		// reset values, read-only places, unmapped index
		wr_reg(`TPL_IDX_STATUS, 32'hFFFFFFFF);
		wr_reg(`TPL_IDX_P1_RISE, 32'hFFFFFFFF);
		for (int i = 0; i < 8; i++) begin
			rd_reg(`TPL_IDX_CONTROL + i, rd);
			check_word("reset value", 32'h00000000, rd);
		end
		rd_reg(16'h6000, rd);
		check_word("unmapped read", 32'h00000000, rd);
		$display("test reset_values done");

		// control read back, enables echoed in status
		kr = $random(seed) & 32'h00003737;
		wr_reg(`TPL_IDX_CONTROL, kr);
		rd_reg(`TPL_IDX_CONTROL, rd);
		check_word("control word", kr, rd);
		rd_reg(`TPL_IDX_STATUS, rd);
		check_word("status enables", kr & 32'h00000101, rd);
		$display("test control_word done");

		// continuous mode, every source and edge choice, unselected source first
		for (int p = 0; p < 2; p++) begin
			for (int src = 0; src < 2; src++) begin
				for (int e = 1; e < 4; e++) begin
					wr_reg(`TPL_IDX_CONTROL, 32'h00000000);
					wr_reg(`TPL_IDX_CONTROL, ctl(p, 1'b1, 1'b1, src[0], e[0], e[1]));
					pulse(src == 1 ? p : 2, kr, kf);
					pulse(src == 1 ? 2 : p, kr, kf);
					if (e[0]) pexp[2 * p] = exp_pos(kr);
					if (e[1]) pexp[2 * p + 1] = exp_pos(kf);
					check_probe(p, st(p, 1'b1, e[0], e[1]));
					rd_reg(`TPL_IDX_P1_RISE_CNT + 2 * p, rd);
					check_word("rise count", 32'(e[0]), rd);
					rd_reg(`TPL_IDX_P1_FALL_CNT + 2 * p, rd);
					check_word("fall count", 32'(e[1]), rd);
				end
			end
		end
		$display("test continuous_capture done");

		// single mode with both edges: one rising capture, then disarm and rearm
		for (int p = 0; p < 2; p++) begin
			wr_reg(`TPL_IDX_CONTROL, 32'h00000000);
			wr_reg(`TPL_IDX_CONTROL, ctl(p, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
			pulse(p, kr, kf);
			pexp[2 * p] = exp_pos(kr);
			pulse(p, kr, kf);
			check_probe(p, st(p, 1'b1, 1'b1, 1'b0));
			wr_reg(`TPL_IDX_CONTROL, ctl(p, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
			check_probe(p, 16'h0000);
			wr_reg(`TPL_IDX_CONTROL, ctl(p, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
			pulse(p, kr, kf);
			pexp[2 * p] = exp_pos(kr);
			check_probe(p, st(p, 1'b1, 1'b1, 1'b0));
		end
		$display("test single_mode done");

		// interrupt: raised by an unmasked event, cleared by reading, masked stays low
		wr_reg(`TPL_IDX_CONTROL, 32'h00000000);
		rd_reg(`TPL_IDX_IRQ_STATUS, rd);
		wr_reg(`TPL_IDX_IRQ_MASK, 32'h00000001);
		wr_reg(`TPL_IDX_CONTROL, ctl(0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1));
		pulse(0, kr, kf);
		check_bit("irq raised", 1'b1, irq);
		rd_reg(`TPL_IDX_IRQ_STATUS, rd);
		check_word("irq status", 32'h00000003, rd);
		repeat (2) @(posedge core_clk);
		#1 check_bit("irq cleared", 1'b0, irq);
		wr_reg(`TPL_IDX_IRQ_MASK, 32'h00000002);
		wr_reg(`TPL_IDX_CONTROL, ctl(0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
		pulse(0, kr, kf);
		check_bit("irq masked", 1'b0, irq);
		rd_reg(`TPL_IDX_IRQ_STATUS, rd);
		check_word("irq status masked", 32'h00000001, rd);
		wr_reg(`TPL_IDX_IRQ_MASK, 32'h00000008);
		wr_reg(`TPL_IDX_CONTROL, ctl(1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
		pulse(1, kr, kf);
		#1 check_bit("irq probe two", 1'b1, irq);
		rd_reg(`TPL_IDX_IRQ_STATUS, rd);
		check_word("irq status probe two", 32'h00000008, rd);
		$display("test interrupt done");

		tally_and_finish;
	end
endmodule
